// [hdl/clr_top.sv]
// Timer access logic: latch, readback, status, byte sequencing, window swap
`timescale 1ns/1ns
module clr_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] pp_rdata,
  input wire logic ext_event_in,
  input wire logic ext_gate_in,
  input wire logic aux_clk_in,
  output logic [7:0] io_rdata_r,
  output logic timer_mapped_r,
  output logic clk_out_r
);
  import clr_pkg::*;

  clr_fmt_t fmt_r [CLR_NCH];
  logic [2:0] mode_r [CLR_NCH];
  logic bcd_r [CLR_NCH];
  logic [CLR_CW-1:0] hold_r [CLR_NCH];
  logic hold_v_r [CLR_NCH];
  logic [7:0] sts_r [CLR_NCH];
  logic sts_v_r [CLR_NCH];
  clr_seq_t rd_seq_r [CLR_NCH];
  clr_seq_t wr_seq_r [CLR_NCH];
  logic [7:0] wlo_r [CLR_NCH];
  logic event_prev_r;
  logic aux_prev_r;

  logic [CLR_CW-1:0] count [CLR_NCH];
  logic null_cnt [CLR_NCH];
  logic out_pin [CLR_NCH];
  logic [CLR_NCH-1:0] tick;
  logic [CLR_NCH-1:0] gate;
  logic [CLR_NCH-1:0] data_wr;
  logic [CLR_NCH-1:0] data_rd;
  logic [CLR_NCH-1:0] cfg_wr;
  logic [CLR_NCH-1:0] lat_cnt;
  logic [CLR_NCH-1:0] lat_sts;
  logic [CLR_NCH-1:0] load_req;
  logic [CLR_NCH-1:0] hold_done;
  logic [CLR_CW-1:0] load_val [CLR_NCH];
  logic [7:0] rd_byte [CLR_NCH];
  logic timer_hit;
  logic ctl_wr;
  logic rb_wr;
  logic swap_wr;
  logic swap_rd;
  logic [1:0] sel;
  clr_fmt_t wfmt;

  assign sel = io_wdata[CLR_SEL_HI:CLR_SEL_LO];
  assign wfmt = clr_fmt_t'(io_wdata[CLR_FMT_HI:CLR_FMT_LO]);
  assign swap_wr = io_wr && io_addr == CLR_OFF_SWAP;
  assign swap_rd = io_rd && io_addr == CLR_OFF_SWAP;
  assign timer_hit = timer_mapped_r && io_addr <= CLR_OFF_CTRL;
  assign ctl_wr = io_wr && timer_hit && io_addr == CLR_OFF_CTRL;
  assign rb_wr = ctl_wr && sel == CLR_SEL_READBACK
    && !io_wdata[CLR_BCD_POS];

  // Counter sources at the connector
  assign tick[0] = ext_event_in && !event_prev_r;
  assign tick[1] = aux_clk_in && !aux_prev_r;
  assign tick[2] = aux_clk_in && !aux_prev_r;
  assign gate[0] = 1'b1;
  assign gate[1] = ext_gate_in;
  assign gate[2] = 1'b1;

  always_ff @(posedge clk) begin
    if (rst) begin
      event_prev_r <= 1'b0;
      aux_prev_r <= 1'b0;
    end else begin
      event_prev_r <= ext_event_in;
      aux_prev_r <= aux_clk_in;
    end
  end

  // Per-counter strobes from the shared window
  always_comb begin
    for (int i = 0; i < CLR_NCH; i++) begin
      data_wr[i] = io_wr && timer_hit && io_addr == 4'(i);
      data_rd[i] = io_rd && timer_hit && io_addr == 4'(i);
      cfg_wr[i] = ctl_wr && sel == 2'(i)
        && wfmt != CLR_FMT_LATCH;
      lat_cnt[i] = (ctl_wr && sel == 2'(i) && wfmt == CLR_FMT_LATCH)
        || (rb_wr && !io_wdata[CLR_RB_CNT_POS]
        && io_wdata[CLR_RB_PICK_LO + i]);
      lat_sts[i] = rb_wr && !io_wdata[CLR_RB_STA_POS]
        && io_wdata[CLR_RB_PICK_LO + i];
      load_req[i] = data_wr[i]
        && (fmt_r[i] != CLR_FMT_PAIR || wr_seq_r[i] == CLR_SEQ_HI);
      hold_done[i] = data_rd[i] && !sts_v_r[i] && hold_v_r[i]
        && (fmt_r[i] != CLR_FMT_PAIR || rd_seq_r[i] == CLR_SEQ_HI);
    end
  end

  // Byte placement of loads and reads
  always_comb begin
    for (int i = 0; i < CLR_NCH; i++) begin
      logic [CLR_CW-1:0] src;
      src = hold_v_r[i] ? hold_r[i] : count[i];
      case (fmt_r[i])
        CLR_FMT_LSB: begin
          load_val[i] = {8'h00, io_wdata};
          rd_byte[i] = src[7:0];
        end
        CLR_FMT_MSB: begin
          load_val[i] = {io_wdata, 8'h00};
          rd_byte[i] = src[15:8];
        end
        CLR_FMT_PAIR: begin
          load_val[i] = {io_wdata, wlo_r[i]};
          rd_byte[i] = (rd_seq_r[i] == CLR_SEQ_HI) ? src[15:8] : src[7:0];
        end
        default: begin
          load_val[i] = {8'h00, io_wdata};
          rd_byte[i] = src[7:0];
        end
      endcase
      if (sts_v_r[i]) begin
        rd_byte[i] = sts_r[i];
      end
    end
  end

  // Counter configuration from control bytes
  always_ff @(posedge clk) begin
    for (int i = 0; i < CLR_NCH; i++) begin
      if (rst) begin
        fmt_r[i] <= CLR_FMT_PAIR;
        mode_r[i] <= CLR_MODE_RST;
        bcd_r[i] <= 1'b0;
      end else if (cfg_wr[i]) begin
        fmt_r[i] <= wfmt;
        mode_r[i] <= io_wdata[CLR_MODE_HI:CLR_MODE_LO];
        bcd_r[i] <= io_wdata[CLR_BCD_POS];
      end
    end
  end

  // Hold register; a pending hold blocks later latches
  always_ff @(posedge clk) begin
    for (int i = 0; i < CLR_NCH; i++) begin
      if (rst) begin
        hold_r[i] <= CLR_COUNT_RST;
        hold_v_r[i] <= 1'b0;
      end else if (cfg_wr[i]) begin
        hold_v_r[i] <= 1'b0;
      end else if (lat_cnt[i] && !hold_v_r[i]) begin
        hold_r[i] <= count[i];
        hold_v_r[i] <= 1'b1;
      end else if (hold_done[i]) begin
        hold_v_r[i] <= 1'b0;
      end
    end
  end

  // Status snapshot; first read after a status latch returns it
  always_ff @(posedge clk) begin
    for (int i = 0; i < CLR_NCH; i++) begin
      if (rst) begin
        sts_r[i] <= CLR_RDATA_RST;
        sts_v_r[i] <= 1'b0;
      end else if (cfg_wr[i]) begin
        sts_v_r[i] <= 1'b0;
      end else if (lat_sts[i] && !sts_v_r[i]) begin
        sts_r[i] <= {out_pin[i], null_cnt[i], fmt_r[i], mode_r[i],
          bcd_r[i]};
        sts_v_r[i] <= 1'b1;
      end else if (data_rd[i] && sts_v_r[i]) begin
        sts_v_r[i] <= 1'b0;
      end
    end
  end

  // Read sequencing flip-flop
  always_ff @(posedge clk) begin
    for (int i = 0; i < CLR_NCH; i++) begin
      if (rst) begin
        rd_seq_r[i] <= CLR_SEQ_LO;
      end else if (cfg_wr[i]) begin
        rd_seq_r[i] <= CLR_SEQ_LO;
      end else if (data_rd[i] && !sts_v_r[i]
          && fmt_r[i] == CLR_FMT_PAIR) begin
        rd_seq_r[i] <= clr_seq_t'(!rd_seq_r[i]);
      end
    end
  end

  // Load sequencing flip-flop and staged low byte
  always_ff @(posedge clk) begin
    for (int i = 0; i < CLR_NCH; i++) begin
      if (rst) begin
        wr_seq_r[i] <= CLR_SEQ_LO;
        wlo_r[i] <= CLR_RDATA_RST;
      end else if (cfg_wr[i]) begin
        wr_seq_r[i] <= CLR_SEQ_LO;
      end else if (data_wr[i] && fmt_r[i] == CLR_FMT_PAIR) begin
        wr_seq_r[i] <= clr_seq_t'(!wr_seq_r[i]);
        if (wr_seq_r[i] == CLR_SEQ_LO) begin
          wlo_r[i] <= io_wdata;
        end
      end
    end
  end

  // Window ownership only; nothing else is touched
  always_ff @(posedge clk) begin
    if (rst) begin
      timer_mapped_r <= CLR_MAPPED_RST;
    end else if (swap_wr) begin
      timer_mapped_r <= 1'b1;
    end else if (swap_rd) begin
      timer_mapped_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      io_rdata_r <= CLR_RDATA_RST;
    end else if (io_rd) begin
      if (io_addr > CLR_OFF_CTRL || io_addr == CLR_OFF_CTRL) begin
        io_rdata_r <= (io_addr == CLR_OFF_CTRL && !timer_mapped_r)
          ? pp_rdata : CLR_RDATA_RST;
      end else if (timer_mapped_r) begin
        io_rdata_r <= rd_byte[io_addr[1:0]];
      end else begin
        io_rdata_r <= pp_rdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clk_out_r <= 1'b0;
    end else begin
      clk_out_r <= out_pin[2];
    end
  end

  for (genvar g = 0; g < CLR_NCH; g++) begin : g_ch
    clr_count_elem u_elem (
      .clk(clk),
      .rst(rst),
      .tick(tick[g]),
      .gate(gate[g]),
      .load_req(load_req[g]),
      .load_val(load_val[g]),
      .mode(mode_r[g]),
      .count_r(count[g]),
      .null_r(null_cnt[g]),
      .out_r(out_pin[g])
    );
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_hold_capture: assert property (
    lat_cnt[0] && !hold_v_r[0] && !cfg_wr[0]
    |=> hold_v_r[0] && hold_r[0] == $past(count[0]))
    else $error("count not captured on latch");
  a_held_read: assert property (
    io_rd && timer_mapped_r && io_addr == CLR_OFF_CNT1 && hold_v_r[1]
    && !sts_v_r[1] && fmt_r[1] == CLR_FMT_PAIR && rd_seq_r[1] == CLR_SEQ_LO
    |=> io_rdata_r == $past(hold_r[1][7:0]))
    else $error("held value not returned");
  a_rb_picks: assert property (
    rb_wr && !io_wdata[CLR_RB_CNT_POS]
    |-> lat_cnt == io_wdata[3:1])
    else $error("readback picks wrong counters");
  a_sts_layout: assert property (
    lat_sts[2] && !sts_v_r[2] && !cfg_wr[2]
    |=> sts_r[2] == {$past(out_pin[2]), $past(null_cnt[2]),
    $past(fmt_r[2]), $past(mode_r[2]), $past(bcd_r[2])})
    else $error("status byte layout wrong");
  a_latch_block: assert property (
    hold_v_r[0] && !hold_done[0] && !cfg_wr[0]
    |=> hold_v_r[0] && $stable(hold_r[0]))
    else $error("second latch overwrote hold");
  a_sts_first: assert property (
    sts_v_r[0] && data_rd[0]
    |=> io_rdata_r == $past(sts_r[0]) && !sts_v_r[0])
    else $error("status not delivered first");
  a_pair_order: assert property (
    fmt_r[0] == CLR_FMT_PAIR && rd_seq_r[0] == CLR_SEQ_LO
    && data_rd[0] && !sts_v_r[0] && !io_wr
    |=> rd_seq_r[0] == CLR_SEQ_HI)
    else $error("pair sequencing did not advance");
  a_seq_home: assert property (
    cfg_wr[1] |=> rd_seq_r[1] == CLR_SEQ_LO
    && wr_seq_r[1] == CLR_SEQ_LO)
    else $error("control byte did not reset sequencing");
  a_swap_in: assert property (
    swap_wr |=> timer_mapped_r)
    else $error("write to swap did not map timer");
  a_swap_out: assert property (
    swap_rd && !swap_wr |=> !timer_mapped_r)
    else $error("read of swap did not unmap timer");
  a_swap_quiet: assert property (
    swap_wr || swap_rd |=> $stable(hold_v_r[2]) && $stable(fmt_r[2]))
    else $error("window swap disturbed timer");
  a_null_flag: assert property (
    load_req[1] |=> null_cnt[1])
    else $error("null count not set on load");

  c_readback_both: cover property (
    rb_wr && !io_wdata[CLR_RB_CNT_POS] && !io_wdata[CLR_RB_STA_POS]);
  c_three_reads: cover property (
    sts_v_r[0] && hold_v_r[0] && data_rd[0] ##[1:8] hold_done[0]);
  c_swap_cycle: cover property (swap_wr ##[1:20] swap_rd);
endmodule

// [hdl/clr_pkg.sv]
// Shared constants and types for the counter latch and readback block
package clr_pkg;
  localparam int CLR_NCH = 3;
  localparam int CLR_CW = 16;
  // Register offsets inside the board window
  localparam logic [3:0] CLR_OFF_CNT0 = 4'h0;
  localparam logic [3:0] CLR_OFF_CNT1 = 4'h1;
  localparam logic [3:0] CLR_OFF_CNT2 = 4'h2;
  localparam logic [3:0] CLR_OFF_CTRL = 4'h3;
  localparam logic [3:0] CLR_OFF_SWAP = 4'hD;
  // Control byte field positions
  localparam int CLR_SEL_HI = 7;
  localparam int CLR_SEL_LO = 6;
  localparam int CLR_FMT_HI = 5;
  localparam int CLR_FMT_LO = 4;
  localparam int CLR_MODE_HI = 3;
  localparam int CLR_MODE_LO = 1;
  localparam int CLR_BCD_POS = 0;
  // Readback command field positions
  localparam int CLR_RB_CNT_POS = 5;
  localparam int CLR_RB_STA_POS = 4;
  localparam int CLR_RB_PICK_LO = 1;
  localparam logic [1:0] CLR_SEL_READBACK = 2'h3;
  // Values after reset
  localparam logic [7:0] CLR_RDATA_RST = 8'h00;
  localparam logic [15:0] CLR_COUNT_RST = 16'h0000;
  localparam logic [2:0] CLR_MODE_RST = 3'h0;
  localparam logic CLR_MAPPED_RST = 1'b0;

  typedef enum logic [1:0] {
    CLR_FMT_LATCH = 2'b00,
    CLR_FMT_LSB = 2'b01,
    CLR_FMT_MSB = 2'b10,
    CLR_FMT_PAIR = 2'b11
  } clr_fmt_t;

  typedef enum logic {
    CLR_SEQ_LO = 1'b0,
    CLR_SEQ_HI = 1'b1
  } clr_seq_t;
endpackage

// [hdl/clr_count_elem.sv]
// Counting element: 16-bit down counter with load transfer and output
`timescale 1ns/1ns
module clr_count_elem (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic gate,
  input wire logic load_req,
  input wire logic [clr_pkg::CLR_CW-1:0] load_val,
  input wire logic [2:0] mode,
  output logic [clr_pkg::CLR_CW-1:0] count_r,
  output logic null_r,
  output logic out_r
);
  import clr_pkg::*;

  logic [CLR_CW-1:0] load_r;
  logic xfer;

  assign xfer = tick && null_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      load_r <= CLR_COUNT_RST;
    end else if (load_req) begin
      load_r <= load_val;
    end
  end

  // New count waits for a clock edge; a fresh load keeps the flag set
  always_ff @(posedge clk) begin
    if (rst) begin
      null_r <= 1'b0;
    end else if (load_req) begin
      null_r <= 1'b1;
    end else if (xfer) begin
      null_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= CLR_COUNT_RST;
    end else if (xfer && !load_req) begin
      count_r <= load_r;
    end else if (tick && gate && !null_r) begin
      if (count_r == 16'h0001 && mode[1]) begin
        count_r <= load_r;
      end else begin
        count_r <= count_r - 16'h0001;
      end
    end
  end

  // Periodic modes toggle at terminal count, others go high and stay
  always_ff @(posedge clk) begin
    if (rst) begin
      out_r <= 1'b0;
    end else if (load_req) begin
      out_r <= (mode != CLR_MODE_RST);
    end else if (tick && gate && !null_r && count_r == 16'h0001) begin
      out_r <= mode[1] ? !out_r : 1'b1;
    end
  end
endmodule

// [dv/clr_host_model.sv]
// Host bus model issuing single I/O reads and writes to the timer block
`timescale 1ns/1ns
module clr_host_model (
  input wire logic clk,
  output logic [3:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata_r
);
  initial begin
    io_addr = 4'hF;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'hA5;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] dat);
    @(posedge clk);
    io_addr <= a;
    io_wdata <= dat;
    io_wr <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
    // Released data shows the inverse, never the old value
    io_wdata <= ~dat;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] dat);
    @(posedge clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    #1;
    dat = io_rdata_r;
  endtask

  // Two-byte transfers always in complete pairs, low byte first
  task automatic wr16(input logic [3:0] a, input logic [15:0] val);
    wr(a, val[7:0]);
    wr(a, val[15:8]);
  endtask

  task automatic rd16(input logic [3:0] a, output logic [15:0] val);
    rd(a, val[7:0]);
    rd(a, val[15:8]);
  endtask
endmodule

// [dv/tb_counter_latch_readback.sv]
// Self-checking bench for the timer latch, readback and window logic
`timescale 1ns/1ns
module tb_counter_latch_readback;
  import clr_pkg::*;
  logic clk;
  logic rst;
  logic [3:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] pp_rdata;
  logic ext_event_in;
  logic ext_gate_in;
  logic aux_clk_in;
  logic [7:0] io_rdata_r;
  logic timer_mapped_r;
  logic clk_out_r;
  logic [7:0] d;
  logic [15:0] v;
  logic [15:0] v0;
  int mismatches;
  int n_checks;

  clr_top dut_u (.clk(clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .pp_rdata(pp_rdata),
    .ext_event_in(ext_event_in), .ext_gate_in(ext_gate_in),
    .aux_clk_in(aux_clk_in), .io_rdata_r(io_rdata_r),
    .timer_mapped_r(timer_mapped_r), .clk_out_r(clk_out_r));

  clr_host_model host_u (.clk(clk), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_r(io_rdata_r));

  task automatic chk(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    if (mismatches == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Rising edges on event (bit 0) and aux clock (bit 1) pins
  task automatic pulse(input logic [1:0] m, input int n);
    repeat (n) begin
      @(posedge clk);
      ext_event_in <= m[0];
      aux_clk_in <= m[1];
      repeat (2) @(posedge clk);
      ext_event_in <= 1'b0;
      aux_clk_in <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  task automatic gate(input logic g);
    @(posedge clk);
    ext_gate_in <= g;
  endtask

  task automatic s_map;
    #1;
    chk("rdata", 16'(io_rdata_r), 16'h0000);
    chk("out2", 16'(clk_out_r), 16'h0000);
    @(posedge clk);
    pp_rdata <= 8'hC3;
    host_u.rd(CLR_OFF_CNT0, d);
    chk("pp", 16'(d), 16'h00C3);
    host_u.wr(CLR_OFF_SWAP, 8'h5A);
    chk("map", 16'(timer_mapped_r), 16'h0001);
    host_u.rd(CLR_OFF_SWAP, d);
    chk("unmap", 16'(timer_mapped_r), 16'h0000);
    host_u.wr(CLR_OFF_SWAP, 8'h00);
  endtask

  task automatic s_latch;
    host_u.wr(CLR_OFF_CTRL, 8'h70);
    host_u.wr16(CLR_OFF_CNT1, 16'h1234);
    // One tick with gate low moves the load in without counting
    pulse(2'b10, 1);
    host_u.wr(CLR_OFF_CTRL, 8'h40);
    gate(1'b1);
    pulse(2'b10, 5);
    host_u.wr(CLR_OFF_CTRL, 8'h40);
    gate(1'b0);
    host_u.rd16(CLR_OFF_CNT1, v);
    chk("held1", v, 16'h1234);
    host_u.rd16(CLR_OFF_CNT1, v);
    chk("live1", v, 16'h122F);
    host_u.rd(CLR_OFF_CNT1, d);
    host_u.wr(CLR_OFF_CTRL, 8'h70);
    host_u.rd16(CLR_OFF_CNT1, v);
    chk("reseq", v, 16'h122F);
  endtask

  task automatic s_status;
    host_u.wr(CLR_OFF_CTRL, 8'h30);
    host_u.wr16(CLR_OFF_CNT0, 16'h0010);
    host_u.wr(CLR_OFF_CTRL, 8'hE2);
    host_u.rd(CLR_OFF_CNT0, d);
    chk("st_new", 16'(d), 16'h0070);
    pulse(2'b01, 1);
    host_u.wr(CLR_OFF_CTRL, 8'h00);
    pulse(2'b01, 1);
    host_u.wr(CLR_OFF_CTRL, 8'hE2);
    host_u.rd(CLR_OFF_CNT0, d);
    chk("st_first", 16'(d), 16'h0030);
    host_u.rd16(CLR_OFF_CNT0, v0);
    chk("held0a", v0, 16'h0010);
    host_u.wr(CLR_OFF_CTRL, 8'hC2);
    host_u.rd(CLR_OFF_CNT0, d);
    chk("st_rb", 16'(d), 16'h0030);
    host_u.rd16(CLR_OFF_CNT0, v);
    chk("held0", v, 16'h000F);
  endtask

  task automatic s_multi;
    host_u.wr(CLR_OFF_CTRL, 8'hD6);
    gate(1'b1);
    pulse(2'b11, 3);
    gate(1'b0);
    host_u.rd16(CLR_OFF_CNT0, v0);
    chk("multi0", v0, 16'h000F);
    host_u.rd16(CLR_OFF_CNT1, v);
    chk("multi1", v, 16'h122F);
  endtask

  task automatic s_clkout;
    host_u.wr(CLR_OFF_CTRL, 8'h90);
    host_u.wr(CLR_OFF_CNT2, 8'h03);
    pulse(2'b10, 2);
    chk("out_lo", 16'(clk_out_r), 16'h0000);
    host_u.rd(CLR_OFF_SWAP, d);
    pulse(2'b10, 2);
    chk("out_hi", 16'(clk_out_r), 16'h0001);
    host_u.wr(CLR_OFF_SWAP, 8'h00);
    host_u.wr(CLR_OFF_CTRL, 8'hE8);
    host_u.rd(CLR_OFF_CNT2, d);
    chk("st2", 16'(d), 16'h0090);
    // High byte only format, then a readback byte with bit 0 set
    host_u.wr(CLR_OFF_CTRL, 8'hA0);
    host_u.wr(CLR_OFF_CNT2, 8'h02);
    pulse(2'b10, 1);
    host_u.rd(CLR_OFF_CNT2, d);
    chk("msb2", 16'(d), 16'h0002);
    host_u.wr(CLR_OFF_CTRL, 8'hE9);
    host_u.rd(CLR_OFF_CNT2, d);
    chk("rb_bit0", 16'(d), 16'h0002);
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up;
  end

  initial begin
    rst = 1'b1;
    pp_rdata = 8'h00;
    ext_event_in = 1'b0;
    ext_gate_in = 1'b0;
    aux_clk_in = 1'b0;
    mismatches = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    s_map;
    s_latch;
    s_status;
    s_multi;
    s_clkout;
    wrap_up;
  end
endmodule
